//--- hdl/mmt_pkg.sv
/*
 * Constants for the multimode timer: register offsets, field positions,
 * reset values and modes.
 * Assumes a plain strobe register port with 8-bit data.
 */
package mmt_pkg;
	localparam logic [3:0] MMT_OFS_CTL      = 4'h0;
	localparam logic [3:0] MMT_OFS_CNT_HI   = 4'h1;
	localparam logic [3:0] MMT_OFS_CNT_LO   = 4'h2;
	localparam logic [3:0] MMT_OFS_RLD_HI   = 4'h3;
	localparam logic [3:0] MMT_OFS_RLD_LO   = 4'h4;
	localparam logic [3:0] MMT_OFS_CAP_HI   = 4'h5;
	localparam logic [3:0] MMT_OFS_CAP_LO   = 4'h6;
	localparam logic [3:0] MMT_OFS_EDGE_POL = 4'h7;
	localparam logic [3:0] MMT_OFS_PORT_SEL = 4'h8;
	localparam logic [3:0] MMT_OFS_EDGE_ST  = 4'h9;
	// Control register fields
	localparam int MMT_CTL_EN      = 7;
	localparam int MMT_CTL_POL     = 6;
	localparam int MMT_CTL_OUTEN   = 5;
	localparam int MMT_CTL_PRE_LSB = 3;
	localparam int MMT_CTL_MODE_LSB = 0;
	localparam logic [7:0]  MMT_CTL_RST  = 8'h00;
	localparam logic [15:0] MMT_CNT_RST  = 16'h0001;
	localparam logic [15:0] MMT_RLD_RST  = 16'hFFFF;
	localparam logic [15:0] MMT_CAP_RST  = 16'h0000;
	localparam logic [7:0]  MMT_PSEL_RST = 8'h00;
	localparam logic [7:0]  MMT_EPOL_RST = 8'h00;
	localparam logic [15:0] MMT_CNT_RESTART = 16'h0001;
	localparam logic [15:0] MMT_CNT_MAX     = 16'hFFFF;
	localparam int MMT_PRE_MAX = 128;
	typedef enum logic [2:0] {
		MMT_ONE_SHOT,
		MMT_CONTINUOUS,
		MMT_COUNTER,
		MMT_CAPTURE,
		MMT_COMPARE
	} mmt_mode_t;
endpackage

//--- hdl/mmt_prescaler.sv
/*
 * Prescaler: one-cycle tick every 2**sel system clocks (1..128).
 * Count is held at zero while run is low, so each enable restarts it.
 */
`timescale 1ns/1ps
`default_nettype none
module mmt_prescaler
	import mmt_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       resetn,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] sel,
	// Tick
	output logic            tick
);
	typedef struct packed {
		logic [6:0] cnt;
	} mmt_pre_state_t;

	mmt_pre_state_t st_q;
	mmt_pre_state_t st_d;
	logic [6:0]     lim;

	always_comb
	begin
		lim = 7'((8'h01 << sel) - 8'h01);
		st_d = st_q;
		tick = 1'b0;
		if (!run)
		begin
			st_d.cnt = 7'h00;
		end
		else if (st_q.cnt >= lim)
		begin
			st_d.cnt = 7'h00;
			tick = 1'b1;
		end
		else
		begin
			st_d.cnt = 7'(st_q.cnt + 7'h01);
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule
`default_nettype wire

//--- hdl/mmt_edge_irq.sv
/*
 * Port edge interrupt routing: per pin index pick Port A or Port D, then
 * detect the chosen edge. Assumes port pins synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mmt_edge_irq
	import mmt_pkg::*;
#(
	parameter int PINS = 8
)
(
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            resetn,
	// Configuration
	input  wire logic [PINS-1:0] pin_source_choice_bit,
	input  wire logic [PINS-1:0] edge_polarity_bit,
	// Pins
	input  wire logic [PINS-1:0] port_a_in,
	input  wire logic [PINS-1:0] port_d_in,
	// Edge pulses
	output logic [PINS-1:0]      edge_hit
);
	typedef struct packed {
		logic [PINS-1:0] prev;
	} mmt_edge_state_t;

	mmt_edge_state_t st_q;
	mmt_edge_state_t st_d;
	logic [PINS-1:0] sel_pin;

	generate
		for (genvar i = 0; i < PINS; i++)
		begin : g_pin
			// 0 routes Port A, 1 routes Port D
			assign sel_pin[i] = pin_source_choice_bit[i] ? port_d_in[i] : port_a_in[i];
			// 1 = rising, 0 = falling
			assign edge_hit[i] = edge_polarity_bit[i] ? (sel_pin[i] & ~st_q.prev[i])
				: (~sel_pin[i] & st_q.prev[i]);
		end
	endgenerate

	always_comb
	begin
		st_d = st_q;
		st_d.prev = sel_pin;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule
`default_nettype wire

//--- hdl/mmt_timer.sv
/*
 * Multimode 16-bit timer with port edge interrupt routing.
 * Assumes a single 10 MHz clock, synchronous pins, one-cycle strobes.
 */
// Local design decisions: the placing of the registers and the plain strobed port.
// What this block does
// - 16-bit up-counter clocked by prescaled clock or timer input per mode.
// - Count FFFFH wraps to 0000H and counting continues.
// - Reload 0001H is shortest; 0000H means 65536 counts.
// - One-shot: at reload interrupt, count 0001H, clear enable, stop.
// - One-shot: output pin inverted for one clock at reload.
// - Continuous: written start count first pass only, then from 0001H.
// - Continuous: always prescaled system clock; period reload times prescale.
// - Counter: timer input edges counted, polarity bit picks edge.
// - Counter: prescaler bypassed, one count per qualifying edge.
// - Counter: at reload interrupt, count 0001H, resume, toggle output.
// - Capture: after capture keep counting; at reload interrupt and continue.
// - Capture value minus start times prescale equals elapsed clocks.
// - Compare: at match interrupt and toggle output; counter not reset.
// - Port select register: one bit per pin 0..7, reset 0.
// - Edge select bit: 0 falling, 1 rising edge interrupt.
`timescale 1ns/1ps
`default_nettype none
module mmt_timer
	import mmt_pkg::*;
#(
	parameter int PINS = 8
)
(
	// Clock and reset
	input  wire logic            ref_clk,
	input  wire logic            resetn,
	// Register port
	input  wire logic [3:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic [7:0]           reg_rdata,
	// Timer pins
	input  wire logic            timer_in,
	output logic                 timer_out,
	output logic                 timer_irq,
	// Port interrupt pins
	input  wire logic [PINS-1:0] port_a_in,
	input  wire logic [PINS-1:0] port_d_in,
	output logic [PINS-1:0]      port_edge_irq
);
	if (PINS < 1 || PINS > 8)
		$error("PINS must be 1..8");

	typedef struct packed {
		logic            en;
		logic            pol;
		logic            out_en;
		logic [1:0]      pre_unused;
		logic [2:0]      pre;
		mmt_mode_t       mode;
		logic [15:0]     cnt;
		logic [15:0]     rld;
		logic [15:0]     cap;
		logic [7:0]      port_sel;
		logic [7:0]      edge_pol;
		logic            out_lvl;
		logic            pulse;
		logic            tin_prev;
		logic [7:0]      rdata;
		logic            irq;
		logic [PINS-1:0] pirq;
		logic            en_prev;
	} mmt_state_t;

	mmt_state_t      st_q;
	mmt_state_t      st_d;
	logic            pre_tick;
	logic [PINS-1:0] edge_hit;
	logic            tin_edge;
	logic            step;
	logic [15:0]     cnt_inc;
	logic            at_rld;
	logic [15:0]     hit_val;

	mmt_prescaler u_pre (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.run     (st_q.en && st_q.mode != MMT_COUNTER),
		.sel     (st_q.pre),
		.tick    (pre_tick)
	);

	mmt_edge_irq #(.PINS(PINS)) u_edge (
		.ref_clk               (ref_clk),
		.resetn                (resetn),
		.pin_source_choice_bit (st_q.port_sel[PINS-1:0]),
		.edge_polarity_bit     (st_q.edge_pol[PINS-1:0]),
		.port_a_in             (port_a_in),
		.port_d_in             (port_d_in),
		.edge_hit              (edge_hit)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.irq = 1'b0;
		st_d.pirq = edge_hit;
		st_d.tin_prev = timer_in;
		st_d.en_prev = st_q.en;
		st_d.rdata = 8'h00;
		// Selected timer input edge: polarity 0 rising, 1 falling
		tin_edge = st_q.pol ? (st_q.tin_prev & ~timer_in) : (~st_q.tin_prev & timer_in);
		// Counter mode ignores prescaler
		step = st_q.en && ((st_q.mode == MMT_COUNTER) ? tin_edge : pre_tick);
		cnt_inc = 16'(st_q.cnt + 16'h0001);
		// Reload 0000H matches after the wrap, i.e. a 65536-count span
		at_rld = (st_q.cnt == st_q.rld);
		hit_val = cnt_inc;
		// One-shot pulse restores level after one cycle
		if (st_q.pulse)
		begin
			st_d.pulse = 1'b0;
			st_d.out_lvl = ~st_q.out_lvl;
		end
		if (step)
		begin
			if (at_rld)
			begin
				st_d.irq = 1'b1;
				case (st_q.mode)
					MMT_ONE_SHOT:
					begin
						hit_val = MMT_CNT_RESTART;
						st_d.en = 1'b0;
						if (st_q.out_en)
						begin
							st_d.out_lvl = ~st_q.out_lvl;
							st_d.pulse = 1'b1;
						end
					end
					MMT_CONTINUOUS, MMT_COUNTER:
					begin
						hit_val = MMT_CNT_RESTART;
						if (st_q.out_en)
							st_d.out_lvl = ~st_q.out_lvl;
					end
					MMT_COMPARE:
					begin
						if (st_q.out_en)
							st_d.out_lvl = ~st_q.out_lvl;
					end
					default:
					begin
						hit_val = cnt_inc;
					end
				endcase
			end
			st_d.cnt = hit_val;
		end
		// Capture on selected input edge
		if (st_q.en && st_q.mode == MMT_CAPTURE && tin_edge)
		begin
			st_d.cap = st_q.cnt;
			st_d.irq = 1'b1;
		end
		if (reg_wr)
		begin
			case (reg_addr)
				MMT_OFS_CTL:
				begin
					st_d.en = reg_wdata[MMT_CTL_EN];
					st_d.pol = reg_wdata[MMT_CTL_POL];
					st_d.out_en = reg_wdata[MMT_CTL_OUTEN];
					st_d.pre = reg_wdata[MMT_CTL_PRE_LSB +: 3] > 3'd7 ? 3'd7
						: reg_wdata[MMT_CTL_PRE_LSB +: 3];
					st_d.mode = (reg_wdata[2:0] > 3'd4) ? MMT_ONE_SHOT
						: mmt_mode_t'(reg_wdata[MMT_CTL_MODE_LSB +: 3]);
				end
				MMT_OFS_CNT_HI:   st_d.cnt[15:8] = reg_wdata;
				MMT_OFS_CNT_LO:   st_d.cnt[7:0] = reg_wdata;
				MMT_OFS_RLD_HI:   st_d.rld[15:8] = reg_wdata;
				MMT_OFS_RLD_LO:   st_d.rld[7:0] = reg_wdata;
				MMT_OFS_CAP_HI:   st_d.cap[15:8] = reg_wdata;
				MMT_OFS_CAP_LO:   st_d.cap[7:0] = reg_wdata;
				MMT_OFS_EDGE_POL: st_d.edge_pol = reg_wdata;
				MMT_OFS_PORT_SEL: st_d.port_sel = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				MMT_OFS_CTL:      st_d.rdata = {st_q.en, st_q.pol, st_q.out_en, st_q.pre[1:0],
					st_q.mode};
				MMT_OFS_CNT_HI:   st_d.rdata = st_q.cnt[15:8];
				MMT_OFS_CNT_LO:   st_d.rdata = st_q.cnt[7:0];
				MMT_OFS_RLD_HI:   st_d.rdata = st_q.rld[15:8];
				MMT_OFS_RLD_LO:   st_d.rdata = st_q.rld[7:0];
				MMT_OFS_CAP_HI:   st_d.rdata = st_q.cap[15:8];
				MMT_OFS_CAP_LO:   st_d.rdata = st_q.cap[7:0];
				MMT_OFS_EDGE_POL: st_d.rdata = st_q.edge_pol;
				MMT_OFS_PORT_SEL: st_d.rdata = st_q.port_sel;
				MMT_OFS_EDGE_ST:  st_d.rdata = {st_q.pre[2], 7'h00};
				default:          st_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			st_q <= '0;
			st_q.cnt <= MMT_CNT_RST;
			st_q.rld <= MMT_RLD_RST;
			st_q.cap <= MMT_CAP_RST;
			st_q.port_sel <= MMT_PSEL_RST;
			st_q.edge_pol <= MMT_EPOL_RST;
		end
		else
			st_q <= st_d;
	end

	assign reg_rdata = st_q.rdata;
	assign timer_out = st_q.out_lvl;
	assign timer_irq = st_q.irq;
	assign port_edge_irq = st_q.pirq;

	// Checks
	wrap_count_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(step && !at_rld && st_q.cnt == MMT_CNT_MAX && !reg_wr) |=> st_q.cnt == 16'h0000)
		else $error("count did not wrap to zero");
	oneshot_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(step && at_rld && st_q.mode == MMT_ONE_SHOT && !reg_wr)
		|=> !st_q.en && st_q.cnt == MMT_CNT_RESTART && timer_irq)
		else $error("one-shot did not stop at reload");
	oneshot_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(step && at_rld && st_q.mode == MMT_ONE_SHOT && st_q.out_en)
		|=> $changed(timer_out) ##1 $changed(timer_out))
		else $error("one-shot pulse not one cycle");
	cont_restart_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(step && at_rld && st_q.mode == MMT_CONTINUOUS && !reg_wr)
		|=> st_q.cnt == MMT_CNT_RESTART && st_q.en)
		else $error("continuous did not restart");
	counter_step_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_q.en && st_q.mode == MMT_COUNTER && !tin_edge && !reg_wr)
		|=> $stable(st_q.cnt))
		else $error("counter moved without edge");
	counter_reload_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(step && at_rld && st_q.mode == MMT_COUNTER && st_q.out_en)
		|=> timer_irq && $changed(timer_out))
		else $error("counter reload missing effects");
	capture_copy_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(st_q.en && st_q.mode == MMT_CAPTURE && tin_edge && !reg_wr)
		|=> st_q.cap == $past(st_q.cnt) && timer_irq)
		else $error("capture did not copy count");
	compare_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(step && at_rld && st_q.mode == MMT_COMPARE && !reg_wr)
		|=> st_q.cnt == 16'($past(st_q.cnt) + 16'h0001) && timer_irq)
		else $error("compare reset the counter");
	read_data_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		(reg_rd && reg_addr == MMT_OFS_PORT_SEL) |=> reg_rdata == $past(st_q.port_sel))
		else $error("port select readback wrong");

	oneshot_cov_c: cover property (@(posedge ref_clk) st_q.mode == MMT_ONE_SHOT && step && at_rld);
	capture_cov_c: cover property (@(posedge ref_clk) st_q.mode == MMT_CAPTURE && tin_edge && st_q.en);
	edge_cov_c: cover property (@(posedge ref_clk) |edge_hit);
endmodule
`default_nettype wire

//--- bench/mmt_pin_model.sv
/*
 * Far-side pin source for the timer input.
 * Assumes the bench asks for levels; it paces them on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module mmt_pin_model
(
	// Clock
	input  wire logic ref_clk,
	// Level asked for by the bench
	input  wire logic want,
	// Timer input pin
	output logic      timer_in
);
	logic [2:0] gap;

	initial
	begin
		timer_in = 1'b0;
		gap = 3'h0;
	end

	// Each level held 4 clocks so the pin never outruns the timer
	always @(posedge ref_clk)
	begin
		if (gap != 3'h0)
			gap <= gap - 3'h1;
		else if (want != timer_in)
		begin
			timer_in <= want;
			gap <= 3'h3;
		end
	end
endmodule
`default_nettype wire

//--- bench/mmt_timer_test.sv
/*
 * Self-checking bench for the multimode timer.
 * Assumes the strobe register port and pin model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module mmt_timer_test
	import mmt_pkg::*;
;
	logic        ref_clk;
	logic        resetn;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        reg_wr;
	logic        reg_rd;
	logic        want;
	logic        timer_in;
	logic        timer_out;
	logic        timer_irq;
	logic        t0;
	logic [7:0]  port_a_in;
	logic [7:0]  port_d_in;
	logic [7:0]  port_edge_irq;
	logic [7:0]  b;
	logic [15:0] v;
	int          n_fail;
	int          n_compared;
	int          irq_cnt;
	int          hi_cnt;
	int          n;

	mmt_timer u_mmt_timer (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.timer_in(timer_in), .timer_out(timer_out), .timer_irq(timer_irq),
		.port_a_in(port_a_in), .port_d_in(port_d_in), .port_edge_irq(port_edge_irq));
	mmt_pin_model u_mmt_pin_model (.ref_clk(ref_clk), .want(want), .timer_in(timer_in));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	always @(negedge ref_clk)
	begin
		if (timer_irq === 1'b1)
			irq_cnt++;
		if (timer_out === 1'b1)
			hi_cnt++;
	end

	task automatic wrap_up;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	task automatic rd16(input logic [3:0] a, output logic [15:0] d);
		logic [7:0] x;
		rd(a, x);
		d[15:8] = x;
		rd(a + 4'h1, x);
		d[7:0] = x;
	endtask

	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		wr(a, d[15:8]);
		wr(a + 4'h1, d[7:0]);
	endtask

	// Configure while stopped, then enable last
	task automatic setup(input logic [7:0] c, input logic [15:0] s, input logic [15:0] r);
		wr(MMT_OFS_CTL, c);
		wr16(MMT_OFS_CNT_HI, s);
		wr16(MMT_OFS_RLD_HI, r);
		wr(MMT_OFS_CTL, c | 8'h80);
	endtask

	task automatic wait_irq(output int k);
		k = 0;
		while (k < 2000)
		begin
			@(negedge ref_clk);
			k++;
			if (timer_irq === 1'b1)
				break;
		end
	endtask

	task automatic pin_try(input logic a, input logic d, input logic exp);
		logic hit;
		hit = 1'b0;
		@(posedge ref_clk);
		port_a_in[0] <= a;
		port_d_in[0] <= d;
		repeat (4)
		begin
			@(negedge ref_clk);
			hit = hit | (port_edge_irq[0] === 1'b1);
		end
		chk("port edge", {15'h0, hit}, {15'h0, exp});
	endtask

	task automatic toggle_in(input logic lvl);
		@(posedge ref_clk);
		want <= lvl;
		repeat (6) @(posedge ref_clk);
	endtask

	initial
	begin
		#500000;
		n_fail++;
		wrap_up;
	end

	initial
	begin
		resetn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		want = 1'b0;
		port_a_in = 8'h00;
		port_d_in = 8'h00;
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		rd16(MMT_OFS_CNT_HI, v);
		chk("count reset", v, MMT_CNT_RST);
		rd16(MMT_OFS_RLD_HI, v);
		chk("reload reset", v, MMT_RLD_RST);
		rd(MMT_OFS_PORT_SEL, b);
		chk("port select reset", {8'h00, b}, 16'h0000);
		rd(4'hF, b);
		chk("unmapped read", {8'h00, b}, 16'h0000);
		wr(MMT_OFS_PORT_SEL, 8'hA5);
		rd(MMT_OFS_PORT_SEL, b);
		chk("port select rw", {8'h00, b}, 16'h00A5);
		wr(MMT_OFS_PORT_SEL, 8'h00);
		wr(MMT_OFS_EDGE_POL, 8'h01);
		pin_try(1'b1, 1'b0, 1'b1);
		pin_try(1'b0, 1'b0, 1'b0);
		wr(MMT_OFS_PORT_SEL, 8'h01);
		pin_try(1'b1, 1'b0, 1'b0);
		pin_try(1'b1, 1'b1, 1'b1);
		wr(MMT_OFS_EDGE_POL, 8'h00);
		pin_try(1'b1, 1'b0, 1'b1);
		// One-shot with output, prescale 16
		irq_cnt = 0;
		hi_cnt = 0;
		setup(8'h20, 16'h0001, 16'h0002);
		repeat (200) @(posedge ref_clk);
		chk("one-shot irqs", 16'(irq_cnt), 16'h0001);
		chk("one-shot pulse", 16'(hi_cnt), 16'h0001);
		rd16(MMT_OFS_CNT_HI, v);
		chk("one-shot count", v, 16'h0001);
		rd(MMT_OFS_CTL, b);
		chk("one-shot enable", {15'h0, b[MMT_CTL_EN]}, 16'h0000);
		// Continuous, prescale 2, reload 5
		setup(8'h09, 16'h0003, 16'h0005);
		wait_irq(n);
		wait_irq(n);
		chk("period one", 16'(n), 16'd10);
		wait_irq(n);
		chk("period two", 16'(n), 16'd10);
		wr(MMT_OFS_CTL, 8'h09);
		// Counter, rising edges, output toggle
		setup(8'h22, 16'h0001, 16'h0004);
		irq_cnt = 0;
		t0 = timer_out;
		toggle_in(1'b1);
		rd16(MMT_OFS_CNT_HI, v);
		chk("edge count", v, 16'h0002);
		toggle_in(1'b0);
		rd16(MMT_OFS_CNT_HI, v);
		chk("falling ignored", v, 16'h0002);
		repeat (3)
		begin
			toggle_in(1'b1);
			toggle_in(1'b0);
		end
		chk("counter irqs", 16'(irq_cnt), 16'h0001);
		rd16(MMT_OFS_CNT_HI, v);
		chk("counter restart", v, MMT_CNT_RESTART);
		chk("counter toggle", {15'h0, timer_out}, {15'h0, ~t0});
		// Compare across the wrap point
		setup(8'h04, 16'hFFFE, 16'h0002);
		irq_cnt = 0;
		repeat (20) @(posedge ref_clk);
		wr(MMT_OFS_CTL, 8'h04);
		chk("compare irqs", 16'(irq_cnt), 16'h0001);
		rd16(MMT_OFS_CNT_HI, v);
		chk("no restart", {15'h0, v > 16'h0004 && v < 16'h0020}, 16'h0001);
		// Capture on a rising input edge
		wr16(MMT_OFS_CAP_HI, 16'h0000);
		setup(8'h03, 16'h0001, 16'hFFFF);
		irq_cnt = 0;
		repeat (40) @(posedge ref_clk);
		toggle_in(1'b1);
		wr(MMT_OFS_CTL, 8'h03);
		chk("capture irq", 16'(irq_cnt), 16'h0001);
		rd16(MMT_OFS_CAP_HI, v);
		v = v - 16'h0001;
		chk("elapsed", {15'h0, v >= 16'd39 && v <= 16'd47}, 16'h0001);
		wrap_up;
	end
endmodule
`default_nettype wire
